// ==== rtl/cewl_top.sv ====
// comparator pair control: synchronises raw results, detects edges and window
// assumes analog front end gives raw results; selections go out as plain ports
`timescale 1ns/10ps
module cewl_top (
    // clock and reset
    input  wire logic                 sys_clk,
    input  wire logic                 rst,
    // configuration
    input  wire cewl_pkg::cewl_cfg_t  cfg_zero,
    input  wire cewl_pkg::cewl_cfg_t  cfg_one,
    input  wire cewl_pkg::cewl_pair_t pair_cfg,
    // analog front end
    input  wire logic [1:0]           raw_result,
    output logic [1:0]                cmp_enable,
    output logic [5:0]                plus_sel_flat,
    output logic [5:0]                minus_sel_flat,
    output logic [5:0]                scale_factor,
    output logic [1:0]                fast_response,
    output logic [3:0]                hysteresis_flat,
    // pins
    output logic                      pin7_out,
    output logic                      pin7_oe_n,
    output logic                      current_enable,
    output logic [2:0]                current_pin,
    // status and events
    output logic [1:0]                result,
    output logic [1:0]                window_state,
    output logic [1:0]                cmp_event,
    output logic [1:0]                cmp_irq,
    output logic [3:0]                cmp_irq_level_flat,
    output logic                      win_event,
    output logic                      win_irq,
    output logic [1:0]                win_irq_level
);
    import cewl_pkg::*;

    cewl_cfg_t cfg [NUM_CMP];
    assign cfg[0] = cfg_zero;
    assign cfg[1] = cfg_one;

    logic [1:0] sync1_r;
    logic [1:0] sync2_r;
    logic [1:0] prev_r;
    logic [1:0] cmp_event_r;
    logic [1:0] wstate_r;
    logic [1:0] wstate_prev_r;
    logic       win_event_r;
    logic       win_valid_r;
    wire  [1:0] cmp_hit;

    ////////////////////////////////////////////////////////////////////////
    // per-comparator selection, enables and edge decode
    genvar g;
    generate
        for (g = 0; g < NUM_CMP; g++) begin : g_cmp
            wire rise = sync2_r[g] & ~prev_r[g];
            wire fall = ~sync2_r[g] & prev_r[g];
            wire hit;
            // edge code decode, reserved code never fires
            assign hit = (cfg[g].edge_select == EDGE_TOGGLE)  ? (rise | fall) :
                         (cfg[g].edge_select == EDGE_FALLING) ? fall :
                         (cfg[g].edge_select == EDGE_RISING)  ? rise : 1'b0;
            assign cmp_hit[g] = hit & cfg[g].enable;
            // selections go straight to the analog muxes
            assign cmp_enable[g] = cfg[g].enable;
            assign plus_sel_flat[g*3 +: 3]  = cfg[g].plus_input_select;
            assign minus_sel_flat[g*3 +: 3] = cfg[g].minus_input_select;
            assign fast_response[g] = cfg[g].fast_response_select;
            assign hysteresis_flat[g*2 +: 2] = cfg[g].hysteresis_select;
            assign cmp_irq_level_flat[g*2 +: 2] = cfg[g].irq_priority;
            // interrupt only with nonzero priority
            assign cmp_irq[g] = cmp_event_r[g] & (cfg[g].irq_priority != 2'h0);
        end
    endgenerate

    // supply scaler and current source
    assign scale_factor   = pair_cfg.scale_factor;
    assign current_enable = pair_cfg.current_enable;
    assign current_pin    = pair_cfg.current_pin_select;
    assign pin7_oe_n      = ~pair_cfg.result_to_pin;
    assign pin7_out       = sync2_r[0] & cfg[0].enable;

    // gated results visible while enabled
    assign result = sync2_r & cmp_enable;
    assign cmp_event = cmp_event_r;

    ////////////////////////////////////////////////////////////////////////
    // window decode: one is lower bound, zero is upper bound
    wire       win_on = pair_cfg.window_enable & cmp_enable[0] & cmp_enable[1];
    wire [1:0] wstate_nxt = sync2_r[1] ? WSTATE_BELOW :
                            (sync2_r[0] ? WSTATE_INSIDE : WSTATE_ABOVE);
    wire       wchg = win_valid_r & (wstate_r != wstate_prev_r);
    wire       whit = (pair_cfg.window_edge_select == WIN_ABOVE)  ?
                          (wchg & (wstate_r == WSTATE_ABOVE)) :
                      (pair_cfg.window_edge_select == WIN_INSIDE) ?
                          (wchg & (wstate_r == WSTATE_INSIDE)) :
                      (pair_cfg.window_edge_select == WIN_BELOW)  ?
                          (wchg & (wstate_r == WSTATE_BELOW)) : wchg;
    assign window_state  = wstate_r;
    assign win_event     = win_event_r;
    assign win_irq_level = pair_cfg.window_irq_priority;
    assign win_irq       = win_event_r & (pair_cfg.window_irq_priority != 2'h0);

    ////////////////////////////////////////////////////////////////////////
    // two-stage synchroniser and previous sample
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sync1_r <= SYNC_RST;
            sync2_r <= SYNC_RST;
            prev_r  <= SYNC_RST;
        end else begin
            sync1_r <= raw_result;
            sync2_r <= sync1_r;
            prev_r  <= sync2_r;
        end
    end

    // comparator event pulses
    always_ff @(posedge sys_clk) begin
        if (rst) cmp_event_r <= 2'h0;
        else     cmp_event_r <= cmp_hit;
    end

    // window state tracking
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wstate_r      <= WSTATE_RST;
            wstate_prev_r <= WSTATE_RST;
            win_valid_r   <= 1'b0;
            win_event_r   <= 1'b0;
        end else begin
            wstate_r      <= win_on ? wstate_nxt : WSTATE_RST;
            // first enabled cycle copies the state, so entry shows no false change
            wstate_prev_r <= win_valid_r ? wstate_r : wstate_nxt;
            win_valid_r   <= win_on;
            win_event_r   <= whit & win_on;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks: synchroniser timing
    // every check is off in reset; all flops are zero there, so the history
    // that the past values see across the release is the idle level
    // the raw result must appear on the second stage exactly two edges later
    a_sync_delay: assert property (@(posedge sys_clk) disable iff (rst)
        ##2 (sync2_r == $past(raw_result, 2))) else $error("sync delay wrong");

    // the previous sample trails the second stage by one edge
    a_prev_sample: assert property (@(posedge sys_clk) disable iff (rst)
        ##1 (prev_r == $past(sync2_r))) else $error("previous sample wrong");

    ////////////////////////////////////////////////////////////////////////
    // checks: per-comparator edge decode, gating and interrupt qualification
    generate
        for (g = 0; g < NUM_CMP; g++) begin : g_chk
            // a rising edge in rising or toggle mode must give a pulse
            a_rise_event: assert property (@(posedge sys_clk) disable iff (rst)
                (cfg[g].enable && sync2_r[g] && !prev_r[g] &&
                 (cfg[g].edge_select == EDGE_RISING || cfg[g].edge_select == EDGE_TOGGLE))
                |=> cmp_event[g]) else $error("rising event missed");

            // a falling edge in falling or toggle mode must give a pulse
            a_fall_event: assert property (@(posedge sys_clk) disable iff (rst)
                (cfg[g].enable && !sync2_r[g] && prev_r[g] &&
                 (cfg[g].edge_select == EDGE_FALLING || cfg[g].edge_select == EDGE_TOGGLE))
                |=> cmp_event[g]) else $error("falling event missed");

            // rising mode ignores falling edges
            a_rise_only: assert property (@(posedge sys_clk) disable iff (rst)
                (cfg[g].edge_select == EDGE_RISING && !sync2_r[g] && prev_r[g])
                |=> !cmp_event[g]) else $error("falling edge fired in rising mode");

            // falling mode ignores rising edges
            a_fall_only: assert property (@(posedge sys_clk) disable iff (rst)
                (cfg[g].edge_select == EDGE_FALLING && sync2_r[g] && !prev_r[g])
                |=> !cmp_event[g]) else $error("rising edge fired in falling mode");

            // the reserved edge code never fires
            a_reserved_quiet: assert property (@(posedge sys_clk) disable iff (rst)
                (cfg[g].edge_select == 2'h1) |=> !cmp_event[g])
                else $error("reserved code fired");

            // no pulse without an edge between consecutive samples
            a_edge_only: assert property (@(posedge sys_clk) disable iff (rst)
                (sync2_r[g] == prev_r[g]) |=> !cmp_event[g])
                else $error("event without edge");

            // a disabled comparator stays silent
            a_off_quiet: assert property (@(posedge sys_clk) disable iff (rst)
                !cfg[g].enable |=> !cmp_event[g]) else $error("disabled comparator fired");

            // the event pulse never depends on the interrupt being enabled
            a_event_no_irq: assert property (@(posedge sys_clk) disable iff (rst)
                (cfg[g].enable && cfg[g].irq_priority == 2'h0 &&
                 cfg[g].edge_select == EDGE_TOGGLE && (sync2_r[g] != prev_r[g]))
                |=> cmp_event[g]) else $error("event lost without interrupt");

            // a nonzero priority turns each pulse into an interrupt
            a_irq_on: assert property (@(posedge sys_clk) disable iff (rst)
                (cmp_event[g] && cfg[g].irq_priority != 2'h0) |-> cmp_irq[g])
                else $error("interrupt missed");

            // zero priority or no pulse keeps the interrupt quiet
            a_irq_gate: assert property (@(posedge sys_clk) disable iff (rst)
                (cfg[g].irq_priority == 2'h0 || !cmp_event[g]) |-> !cmp_irq[g])
                else $error("interrupt without event or priority");

            // a disabled comparator shows zero to software
            a_result_gate: assert property (@(posedge sys_clk) disable iff (rst)
                !cmp_enable[g] |-> !result[g]) else $error("disabled result shown");

            // an enabled comparator shows its raw result two edges late
            a_result_follow: assert property (@(posedge sys_clk) disable iff (rst)
                cmp_enable[g] |-> (result[g] == $past(raw_result[g], 2)))
                else $error("result does not follow input");

            // the selections reach the analog muxes unchanged
            a_select_pass: assert property (@(posedge sys_clk) disable iff (rst)
                (plus_sel_flat[g*3 +: 3] == cfg[g].plus_input_select &&
                 minus_sel_flat[g*3 +: 3] == cfg[g].minus_input_select))
                else $error("input selection lost");

            // speed, hysteresis and priority settings pass straight through
            a_setting_pass: assert property (@(posedge sys_clk) disable iff (rst)
                (fast_response[g] == cfg[g].fast_response_select &&
                 hysteresis_flat[g*2 +: 2] == cfg[g].hysteresis_select &&
                 cmp_irq_level_flat[g*2 +: 2] == cfg[g].irq_priority))
                else $error("comparator setting lost");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // checks: window operation
    // the window state follows the decode one edge later while enabled
    a_window_state: assert property (@(posedge sys_clk) disable iff (rst)
        win_on |=> (window_state == $past(wstate_nxt))) else $error("window state wrong");

    // window off parks the state at its reset value and stays silent
    a_window_off: assert property (@(posedge sys_clk) disable iff (rst)
        !win_on |=> (window_state == WSTATE_RST && !win_event))
        else $error("window active while off");

    // comparator one high means below, whatever comparator zero says
    a_window_below: assert property (@(posedge sys_clk) disable iff (rst)
        (win_on && sync2_r[1]) |=> (window_state == WSTATE_BELOW))
        else $error("below state wrong");

    // only comparator zero high means inside
    a_window_inside: assert property (@(posedge sys_clk) disable iff (rst)
        (win_on && !sync2_r[1] && sync2_r[0]) |=> (window_state == WSTATE_INSIDE))
        else $error("inside state wrong");

    // above mode pulses on entry into the above state
    a_window_above: assert property (@(posedge sys_clk) disable iff (rst)
        (win_on && pair_cfg.window_edge_select == WIN_ABOVE && wchg &&
         wstate_r == WSTATE_ABOVE) |=> win_event) else $error("above event missed");

    // inside mode pulses on entry into the inside state
    a_window_entry: assert property (@(posedge sys_clk) disable iff (rst)
        (win_on && pair_cfg.window_edge_select == WIN_INSIDE && wchg &&
         wstate_r == WSTATE_INSIDE) |=> win_event) else $error("inside event missed");

    // below mode pulses on entry into the below state
    a_window_low: assert property (@(posedge sys_clk) disable iff (rst)
        (win_on && pair_cfg.window_edge_select == WIN_BELOW && wchg &&
         wstate_r == WSTATE_BELOW) |=> win_event) else $error("below event missed");

    // change mode pulses on every entry into a new state
    a_window_change: assert property (@(posedge sys_clk) disable iff (rst)
        (win_on && pair_cfg.window_edge_select == WIN_CHANGE && wchg) |=> win_event)
        else $error("change event missed");

    // a steady window state never pulses
    a_window_steady: assert property (@(posedge sys_clk) disable iff (rst)
        (wstate_r == wstate_prev_r) |=> !win_event) else $error("window event without change");

    // the window interrupt needs a nonzero priority
    a_window_irq: assert property (@(posedge sys_clk) disable iff (rst)
        win_irq == (win_event && pair_cfg.window_irq_priority != 2'h0))
        else $error("window interrupt wrong");

    ////////////////////////////////////////////////////////////////////////
    // checks: pin output and current source
    // with the pin routed, it carries comparator zero's visible result
    a_pin_drive: assert property (@(posedge sys_clk) disable iff (rst)
        pair_cfg.result_to_pin |-> (!pin7_oe_n && pin7_out == result[0]))
        else $error("pin not driven");

    // without the routing bit the pin is left to the port
    a_pin_release: assert property (@(posedge sys_clk) disable iff (rst)
        !pair_cfg.result_to_pin |-> pin7_oe_n) else $error("pin driven while off");

    // the current source follows its enable and pin selection
    a_current_pass: assert property (@(posedge sys_clk) disable iff (rst)
        (current_enable == pair_cfg.current_enable &&
         current_pin == pair_cfg.current_pin_select)) else $error("current source lost");

    // the scaler level reaches the analog side unchanged
    a_scaler_pass: assert property (@(posedge sys_clk) disable iff (rst)
        scale_factor == pair_cfg.scale_factor) else $error("scaler level lost");

    ////////////////////////////////////////////////////////////////////////
    // covers for the main scenarios
    c_rise: cover property (@(posedge sys_clk) cmp_event[0] && cmp_irq[0]);
    c_one_event: cover property (@(posedge sys_clk) cmp_event[1]);
    c_win_inside: cover property (@(posedge sys_clk) win_event && window_state == WSTATE_INSIDE);
    c_win_below: cover property (@(posedge sys_clk) win_event && window_state == WSTATE_BELOW);
    c_win_irq: cover property (@(posedge sys_clk) win_irq);
endmodule : cewl_top

// ==== shared/cewl_pkg.sv ====
// comparator edge and window logic: shared constants and carriers
// assumes one peripheral clock and a synchronous active-high reset
package cewl_pkg;
    localparam int NUM_CMP = 2;
    // edge select codes
    localparam logic [1:0] EDGE_TOGGLE  = 2'h0;
    localparam logic [1:0] EDGE_FALLING = 2'h2;
    localparam logic [1:0] EDGE_RISING  = 2'h3;
    // window edge select codes
    localparam logic [1:0] WIN_ABOVE    = 2'h0;
    localparam logic [1:0] WIN_INSIDE   = 2'h1;
    localparam logic [1:0] WIN_BELOW    = 2'h2;
    localparam logic [1:0] WIN_CHANGE   = 2'h3;
    // window state encodings
    localparam logic [1:0] WSTATE_BELOW  = 2'h0;
    localparam logic [1:0] WSTATE_INSIDE = 2'h1;
    localparam logic [1:0] WSTATE_ABOVE  = 2'h2;
    // reset values
    localparam logic [1:0] SYNC_RST = 2'h0;
    localparam logic [1:0] WSTATE_RST = WSTATE_BELOW;

    // per-comparator configuration
    typedef struct packed {
        logic [1:0] edge_select;
        logic [1:0] irq_priority;
        logic       fast_response_select;
        logic [1:0] hysteresis_select;
        logic       enable;
        logic [2:0] plus_input_select;
        logic [2:0] minus_input_select;
    } cewl_cfg_t;

    // pair-wide configuration
    typedef struct packed {
        logic       window_enable;
        logic [1:0] window_edge_select;
        logic [1:0] window_irq_priority;
        logic       result_to_pin;
        logic [5:0] scale_factor;
        logic       current_enable;
        logic [2:0] current_pin_select;
    } cewl_pair_t;
endpackage : cewl_pkg

// ==== bench/cewl_afe_model.sv ====
// analog front end model: two comparators fed by levels the bench sets
// assumes plain numeric levels; a disabled comparator reads low
`timescale 1ns/10ps
module cewl_afe_model (
    // levels from the bench
    input  wire logic [1:0][11:0] plus_mv,
    input  wire logic [1:0][11:0] minus_mv,
    // block side
    input  wire logic [1:0]       cmp_enable,
    output logic [1:0]            raw_result
);
    // one only when plus strictly exceeds minus
    assign raw_result[0] = cmp_enable[0] & (plus_mv[0] > minus_mv[0]);
    assign raw_result[1] = cmp_enable[1] & (plus_mv[1] > minus_mv[1]);
endmodule : cewl_afe_model

// ==== bench/tb_cewl_top.sv ====
// bench for the comparator pair logic: edge modes, window, pin, passthrough
// assumes the front end model above and the shared package
`timescale 1ns/10ps
module tb_cewl_top;
    import cewl_pkg::*;
    logic sys_clk, rst, pin7_out, pin7_oe_n, current_enable, win_event, win_irq;
    cewl_cfg_t cfg_zero, cfg_one;
    cewl_pair_t pair_cfg;
    logic [1:0][11:0] plus_mv, minus_mv;
    logic [1:0] raw_result, cmp_enable, fast_response, result, window_state;
    logic [1:0] cmp_event, cmp_irq, win_irq_level;
    logic [5:0] plus_sel_flat, minus_sel_flat, scale_factor;
    logic [3:0] hysteresis_flat, cmp_irq_level_flat;
    logic [2:0] current_pin;
    int n_errors, total_checks, ev0, ev1, irq0, wev, wirq;
    int cyc = 0;
    cewl_top i_cewl_top (.sys_clk, .rst, .cfg_zero, .cfg_one, .pair_cfg, .raw_result,
        .cmp_enable, .plus_sel_flat, .minus_sel_flat, .scale_factor, .fast_response,
        .hysteresis_flat, .pin7_out, .pin7_oe_n, .current_enable, .current_pin, .result,
        .window_state, .cmp_event, .cmp_irq, .cmp_irq_level_flat, .win_event, .win_irq,
        .win_irq_level);
    cewl_afe_model i_cewl_afe_model (.plus_mv, .minus_mv, .cmp_enable, .raw_result);
    ////////////////////////////////////////////////////////////////////////////
    // clock and hang guard
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_errors++;
            summarize();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic ok, input string m);
        total_checks++;
        if (ok !== 1'b1) begin
            n_errors++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask : chk
    // set which comparators see plus high, then count pulses over eight cycles
    task automatic lvl(input logic [1:0] hi);
        @(posedge sys_clk);
        plus_mv[0] <= hi[0] ? 12'h064 : 12'h000;
        plus_mv[1] <= hi[1] ? 12'h064 : 12'h000;
        ev0 = 0;
        ev1 = 0;
        irq0 = 0;
        wev = 0;
        wirq = 0;
        repeat (8) begin
            @(negedge sys_clk);
            // an unknown pulse counts as a pulse, so it cannot hide
            ev0 += (cmp_event[0] === 1'b0) ? 0 : 1;
            ev1 += (cmp_event[1] === 1'b0) ? 0 : 1;
            irq0 += (cmp_irq[0] === 1'b0) ? 0 : 1;
            wev += (win_event === 1'b0) ? 0 : 1;
            wirq += (win_irq === 1'b0) ? 0 : 1;
        end
    endtask : lvl
    // every edge code, priority on for nonzero codes only
    task automatic t_edges;
        logic [1:0] c;
        int er;
        int ef;
        for (int k = 0; k < 4; k++) begin
            c = 2'(k);
            er = int'(c == EDGE_TOGGLE || c == EDGE_RISING);
            ef = int'(c == EDGE_TOGGLE || c == EDGE_FALLING);
            @(posedge sys_clk);
            cfg_zero.edge_select <= c;
            cfg_zero.irq_priority <= c;
            lvl(2'h1);
            chk(result[0] === 1'b1, "result not high");
            chk(ev0 == er, "rise event count");
            chk(irq0 == ((c != 2'h0) ? er : 0), "rise irq count");
            lvl(2'h0);
            chk(ev0 == ef && ev1 == 0, "fall event count");
            chk(irq0 == ((c != 2'h0) ? ef : 0), "fall irq count");
        end
        $display("test edges done");
    endtask : t_edges
    // window above then inside then change then below
    task automatic t_window;
        @(posedge sys_clk);
        cfg_one.enable <= 1'b1;
        pair_cfg.window_enable <= 1'b1;
        pair_cfg.window_edge_select <= WIN_ABOVE;
        pair_cfg.window_irq_priority <= 2'h1;
        lvl(2'h1);
        chk(window_state === WSTATE_INSIDE && wev == 0, "inside state");
        lvl(2'h0);
        chk(window_state === WSTATE_ABOVE && wev == 1, "above event");
        chk(wirq == 1 && win_irq_level === 2'h1, "above irq");
        @(posedge sys_clk);
        pair_cfg.window_edge_select <= WIN_INSIDE;
        lvl(2'h1);
        chk(window_state === WSTATE_INSIDE && wev == 1, "inside event");
        lvl(2'h3);
        chk(window_state === WSTATE_BELOW && wev == 0, "below state");
        chk(ev1 == 1, "comparator one event");
        @(posedge sys_clk);
        pair_cfg.window_edge_select <= WIN_CHANGE;
        lvl(2'h1);
        chk(window_state === WSTATE_INSIDE && wev == 1 && ev1 == 1, "change event");
        @(posedge sys_clk);
        pair_cfg.window_edge_select <= WIN_BELOW;
        pair_cfg.window_irq_priority <= 2'h0;
        lvl(2'h3);
        chk(window_state === WSTATE_BELOW && wev == 1 && wirq == 0, "below event");
        $display("test window done");
    endtask : t_window
    // pin output, current source, selections, disabled comparator
    task automatic t_pins;
        chk(pin7_oe_n === 1'b1, "pin released");
        @(posedge sys_clk);
        pair_cfg.window_enable <= 1'b0;
        pair_cfg.result_to_pin <= 1'b1;
        pair_cfg.current_enable <= 1'b1;
        pair_cfg.current_pin_select <= 3'h5;
        pair_cfg.scale_factor <= 6'h3f;
        cfg_one.enable <= 1'b0;
        cfg_one.fast_response_select <= 1'b1;
        cfg_one.hysteresis_select <= 2'h2;
        cfg_one.irq_priority <= 2'h2;
        lvl(2'h3);
        chk(fast_response === 2'h2 && hysteresis_flat === 4'h8, "speed and hysteresis");
        chk(cmp_irq_level_flat === 4'hb, "priority levels");
        chk(pin7_oe_n === 1'b0 && pin7_out === 1'b1, "pin drive");
        chk(current_enable === 1'b1 && current_pin === 3'h5, "current source");
        chk(scale_factor === 6'h3f && minus_sel_flat === 6'h38, "scaler select");
        chk(plus_sel_flat === 6'h22 && cmp_enable === 2'h1, "input select");
        chk(result === 2'h1, "disabled result");
        $display("test pins done");
    endtask : t_pins
    task automatic summarize;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : summarize
    ////////////////////////////////////////////////////////////////////////////
    // reset, configure before enable, run scenarios
    initial begin
        {cfg_zero, cfg_one, pair_cfg, plus_mv} = '0;
        minus_mv = {12'h032, 12'h032};
        rst = 1'b1;
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        cfg_zero.plus_input_select <= 3'h2;
        cfg_one.plus_input_select <= 3'h4;
        cfg_one.minus_input_select <= 3'h7;
        @(posedge sys_clk);
        cfg_zero.enable <= 1'b1;
        t_edges();
        t_window();
        t_pins();
        summarize();
    end
endmodule : tb_cewl_top
